// ==== tlvi_defines.svh ====
`ifndef TLVI_DEFINES_SVH
`define TLVI_DEFINES_SVH

// Number of polled slots, slot 0 is the reserved one.
`define TLVI_NSLOT        13

// Polling slots, lowest index polled first.
`define TLVI_SLOT_RSVD    4'h0
`define TLVI_SLOT_EXT0    4'h1
`define TLVI_SLOT_TMR0    4'h2
`define TLVI_SLOT_EXT1    4'h3
`define TLVI_SLOT_TMR1    4'h4
`define TLVI_SLOT_UARTA   4'h5
`define TLVI_SLOT_TMR2    4'h6
`define TLVI_SLOT_SPI     4'h7
`define TLVI_SLOT_USB     4'h8
`define TLVI_SLOT_I2C     4'h9
`define TLVI_SLOT_ADC     4'hA
`define TLVI_SLOT_CARR    4'hB
`define TLVI_SLOT_UARTB   4'hC

// Vector addresses in program memory.
`define TLVI_VEC_RSVD     16'h0063
`define TLVI_VEC_EXT0     16'h0003
`define TLVI_VEC_TMR0     16'h000B
`define TLVI_VEC_EXT1     16'h0013
`define TLVI_VEC_TMR1     16'h001B
`define TLVI_VEC_UARTA    16'h0023
`define TLVI_VEC_TMR2     16'h002B
`define TLVI_VEC_USB      16'h0033
`define TLVI_VEC_ADC      16'h003B
`define TLVI_VEC_I2C      16'h0043
`define TLVI_VEC_SPI      16'h0053
`define TLVI_VEC_CARR     16'h005B
`define TLVI_VEC_UARTB    16'h006B

// Bit positions in the enable and priority registers.
`define TLVI_BIT_GATE     7
`define TLVI_BIT_A_USB    0
`define TLVI_BIT_A_I2C    1
`define TLVI_BIT_A_UARTB  4
`define TLVI_BIT_A_CARR   5
`define TLVI_BIT_A_SPI    6
`define TLVI_BIT_A_ADC    7

// Bit positions in the timer, timer 2, I2C status and ADC control registers.
`define TLVI_BIT_IT0      0
`define TLVI_BIT_IT1      2
`define TLVI_BIT_TF0      5
`define TLVI_BIT_TF1      7
`define TLVI_BIT_TF2      7
`define TLVI_BIT_TIMER2_EXTERNAL_FLAG     6
`define TLVI_BIT_I2C      5
`define TLVI_BIT_ADC      7

// Slots whose flag is always cleared by hardware on vectoring.
`define TLVI_AUTO_CLR     13'h0_294

`endif

// ==== tlvi_pkg.sv ====
`default_nettype none
package tlvi_pkg;

  typedef struct packed {
    logic [12:0] sample;
    logic        call;
    logic [15:0] vec;
    logic [3:0]  idx;
    logic        svc_hi;
    logic        svc_lo;
    logic [12:0] hw_clr;
  } tlvi_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic flag;
  } tlvi_ext_state_t;

endpackage
`default_nettype wire

// ==== tlvi_ext_flag.sv ====
`default_nettype none
`include "tlvi_defines.svh"
module tlvi_ext_flag
  import tlvi_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and control
  input  wire logic pin,
  input  wire logic trig_edge,
  input  wire logic clr,
  // Pending flag
  output logic      flag
);

  tlvi_ext_state_t q;
  tlvi_ext_state_t d;

  always_comb begin
    d       = q;
    d.sync1 = pin;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    if (trig_edge) begin
      // A falling edge in the clearing cycle is kept.
      if (q.prev && !q.sync2) begin
        d.flag = 1'b1;
      end else if (clr) begin
        d.flag = 1'b0;
      end
    end else begin
      // Level mode tracks the pin, so only the source can drop it.
      d.flag = !q.sync2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, flag: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign flag = q.flag;

endmodule
`default_nettype wire

// ==== tlvi_poll_pick.sv ====
`default_nettype none
`include "tlvi_defines.svh"
module tlvi_poll_pick
  import tlvi_pkg::*;
(
  // Requests and levels
  input  wire logic [12:0] req,
  input  wire logic [12:0] prio_hi,
  // Winner
  output logic             found,
  output logic             win_hi,
  output logic [3:0]       win_idx
);

  function automatic logic [3:0] first_set(input logic [12:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `TLVI_NSLOT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [12:0] req_hi;
  logic [12:0] req_lo;

  assign req_hi = req & prio_hi;
  assign req_lo = req & ~prio_hi;

  // The high level is searched first, then polling order inside it.
  always_comb begin
    found   = |req;
    win_hi  = |req_hi;
    win_idx = win_hi ? first_set(req_hi) : first_set(req_lo);
  end

endmodule
`default_nettype wire

// ==== tlvi_ctrl.sv ====
`default_nettype none
`include "tlvi_defines.svh"
module tlvi_ctrl
  import tlvi_pkg::*;
#(
  parameter logic [15:0] VEC_UARTB = `TLVI_VEC_UARTB
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Core timing and instruction state
  input  wire logic        mcyc_start,
  input  wire logic        last_cycle,
  input  wire logic        wr_irq_reg,
  input  wire logic        return_from_interrupt,
  // Enable and priority registers
  input  wire logic [7:0]  enable_reg_primary,
  input  wire logic [7:0]  enable_reg_additional,
  input  wire logic [7:0]  priority_reg_primary,
  input  wire logic [7:0]  priority_reg_additional,
  // External interrupt pins
  input  wire logic        external_irq_a,
  input  wire logic        external_irq_b,
  // Peripheral flag registers
  input  wire logic [7:0]  timer_control_reg,
  input  wire logic [7:0]  timer2_control_reg,
  input  wire logic [7:0]  uart_a_control_reg,
  input  wire logic [7:0]  uart_b_control_reg,
  input  wire logic [7:0]  spi_status_reg,
  input  wire logic [7:0]  i2c_status_reg,
  input  wire logic [7:0]  adc_control_reg,
  input  wire logic [7:0]  counter_array_status_reg,
  input  wire logic [31:0] usb_flag_regs,
  // Call request to the core
  output logic             long_call,
  output logic [15:0]      vector_addr,
  // In-service levels
  output logic             service_hi,
  output logic             service_lo,
  // Pending flags owned here
  output logic             ext0_pending,
  output logic             ext1_pending,
  // Hardware flag clears, one per slot
  output logic [12:0]      hw_clear
);

  tlvi_state_t q;
  tlvi_state_t d;

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    logic [15:0] v;
    v = `TLVI_VEC_RSVD;
    unique case (s)
      `TLVI_SLOT_EXT0:  v = `TLVI_VEC_EXT0;
      `TLVI_SLOT_TMR0:  v = `TLVI_VEC_TMR0;
      `TLVI_SLOT_EXT1:  v = `TLVI_VEC_EXT1;
      `TLVI_SLOT_TMR1:  v = `TLVI_VEC_TMR1;
      `TLVI_SLOT_UARTA: v = `TLVI_VEC_UARTA;
      `TLVI_SLOT_TMR2:  v = `TLVI_VEC_TMR2;
      `TLVI_SLOT_SPI:   v = `TLVI_VEC_SPI;
      `TLVI_SLOT_USB:   v = `TLVI_VEC_USB;
      `TLVI_SLOT_I2C:   v = `TLVI_VEC_I2C;
      `TLVI_SLOT_ADC:   v = `TLVI_VEC_ADC;
      `TLVI_SLOT_CARR:  v = `TLVI_VEC_CARR;
      `TLVI_SLOT_UARTB: v = VEC_UARTB;
      default:          v = `TLVI_VEC_RSVD;
    endcase
    return v;
  endfunction

  // Maps the primary and additional register layout onto slots.
  function automatic logic [12:0] to_slots(input logic [7:0] pri,
                                           input logic [7:0] add);
    logic [12:0] s;
    s                   = '0;
    s[6:1]              = pri[5:0];
    s[`TLVI_SLOT_USB]   = add[`TLVI_BIT_A_USB];
    s[`TLVI_SLOT_I2C]   = add[`TLVI_BIT_A_I2C];
    s[`TLVI_SLOT_UARTB] = add[`TLVI_BIT_A_UARTB];
    s[`TLVI_SLOT_CARR]  = add[`TLVI_BIT_A_CARR];
    s[`TLVI_SLOT_SPI]   = add[`TLVI_BIT_A_SPI];
    s[`TLVI_SLOT_ADC]   = add[`TLVI_BIT_A_ADC];
    return s;
  endfunction

  logic        ext0_flag;
  logic        ext1_flag;
  logic        ext0_edge;
  logic        ext1_edge;
  logic [12:0] raw;
  logic [12:0] en;
  logic [12:0] prio_hi;
  logic [12:0] req;
  logic        gate;
  logic        found;
  logic        win_hi;
  logic [3:0]  win_idx;
  logic        blocked;
  logic        busy;
  logic        grant;
  logic        return_from_interrupt_done;
  logic [12:0] auto_clr;

  assign ext0_edge = timer_control_reg[`TLVI_BIT_IT0];
  assign ext1_edge = timer_control_reg[`TLVI_BIT_IT1];

  tlvi_ext_flag u_ext0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (external_irq_a),
    .trig_edge (ext0_edge),
    .clr       (q.hw_clr[`TLVI_SLOT_EXT0]),
    .flag      (ext0_flag)
  );

  tlvi_ext_flag u_ext1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (external_irq_b),
    .trig_edge (ext1_edge),
    .clr       (q.hw_clr[`TLVI_SLOT_EXT1]),
    .flag      (ext1_flag)
  );

  // The reserved slot has no flag source and never requests.
  always_comb begin
    raw                   = '0;
    raw[`TLVI_SLOT_EXT0]  = ext0_flag;
    raw[`TLVI_SLOT_TMR0]  = timer_control_reg[`TLVI_BIT_TF0];
    raw[`TLVI_SLOT_EXT1]  = ext1_flag;
    raw[`TLVI_SLOT_TMR1]  = timer_control_reg[`TLVI_BIT_TF1];
    raw[`TLVI_SLOT_UARTA] = |uart_a_control_reg[1:0];
    raw[`TLVI_SLOT_TMR2]  = timer2_control_reg[`TLVI_BIT_TF2]
                          | timer2_control_reg[`TLVI_BIT_TIMER2_EXTERNAL_FLAG];
    raw[`TLVI_SLOT_SPI]   = |spi_status_reg[3:0];
    raw[`TLVI_SLOT_USB]   = |usb_flag_regs;
    raw[`TLVI_SLOT_I2C]   = i2c_status_reg[`TLVI_BIT_I2C];
    raw[`TLVI_SLOT_ADC]   = adc_control_reg[`TLVI_BIT_ADC];
    raw[`TLVI_SLOT_CARR]  = |counter_array_status_reg;
    raw[`TLVI_SLOT_UARTB] = |uart_b_control_reg[1:0];
  end

  assign gate    = enable_reg_primary[`TLVI_BIT_GATE];
  assign en      = to_slots(enable_reg_primary, enable_reg_additional);
  assign prio_hi = to_slots(priority_reg_primary, priority_reg_additional);
  assign req     = q.sample & en & {13{gate}};

  tlvi_poll_pick u_pick (
    .req     (req),
    .prio_hi (prio_hi),
    .found   (found),
    .win_hi  (win_hi),
    .win_idx (win_idx)
  );

  // A low routine in service never blocks a high winner, which is the preemption path.
  assign busy      = q.svc_hi || (!win_hi && q.svc_lo);
  assign blocked   = busy || !last_cycle || wr_irq_reg
                   || return_from_interrupt;
  assign grant     = mcyc_start && found && !blocked;
  assign return_from_interrupt_done = mcyc_start && last_cycle && return_from_interrupt;

  // Edge-mode external flags clear on vectoring, level-mode ones do not.
  always_comb begin
    auto_clr                  = `TLVI_AUTO_CLR;
    auto_clr[`TLVI_SLOT_EXT0] = ext0_edge;
    auto_clr[`TLVI_SLOT_EXT1] = ext1_edge;
  end

  always_comb begin
    d        = q;
    d.call   = 1'b0;
    d.hw_clr = '0;
    if (mcyc_start) begin
      // Only the newest sample is polled, so a denied request is polled again only while its flag is still set.
      d.sample = raw;
      if (grant) begin
        d.call = 1'b1;
        d.vec  = vec_of(win_idx);
        d.idx  = win_idx;
        if (win_hi) begin
          d.svc_hi = 1'b1;
        end else begin
          d.svc_lo = 1'b1;
        end
        d.hw_clr[win_idx] = auto_clr[win_idx];
      end else if (return_from_interrupt_done) begin
        // A plain return has no input here, so it cannot end a level.
        if (q.svc_hi) begin
          d.svc_hi = 1'b0;
        end else begin
          d.svc_lo = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign long_call   = q.call;
  assign vector_addr = q.vec;
  assign service_hi  = q.svc_hi;
  assign service_lo  = q.svc_lo;
  assign hw_clear    = q.hw_clr;

  // Pending flags are registered inside the edge units.
  assign ext0_pending = ext0_flag;
  assign ext1_pending = ext1_flag;

  AST_CALL_ON_POLL: assert property (@(posedge clk) disable iff (!rst_n)
    long_call |-> $past(mcyc_start))
    else $error("call raised outside a poll");

  AST_BLOCKED_NO_CALL: assert property (@(posedge clk) disable iff (!rst_n)
    mcyc_start && (!last_cycle || wr_irq_reg || return_from_interrupt) |=> !long_call)
    else $error("call raised in a blocked cycle");

  AST_GATE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    mcyc_start && !gate |=> !long_call)
    else $error("call raised with gate closed");

  AST_HI_EXCLUSIVE: assert property (@(posedge clk) disable iff (!rst_n)
    long_call |-> !$past(service_hi))
    else $error("call raised while high level in service");

  AST_LO_NEEDS_HI: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && $past(service_lo) |-> service_hi && !$past(service_hi))
    else $error("low routine interrupted by non-high request");

  AST_VEC_EXT0: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && q.idx == `TLVI_SLOT_EXT0 |-> vector_addr == `TLVI_VEC_EXT0)
    else $error("wrong vector for external input a");

  AST_TMR0_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && q.idx == `TLVI_SLOT_TMR0 |-> hw_clear[`TLVI_SLOT_TMR0] ##1 !hw_clear[`TLVI_SLOT_TMR0])
    else $error("timer 0 flag not cleared by one pulse");

  AST_NO_CLEAR_UART: assert property (@(posedge clk) disable iff (!rst_n)
    !hw_clear[`TLVI_SLOT_UARTA] && !hw_clear[`TLVI_SLOT_USB])
    else $error("software-cleared flag cleared by hardware");

  AST_RETURN_FROM_INTERRUPT_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
    mcyc_start && last_cycle && return_from_interrupt && service_hi |=> !service_hi)
    else $error("return did not end high level");

  AST_SAMPLE_USED: assert property (@(posedge clk) disable iff (!rst_n)
    mcyc_start && !q.sample[`TLVI_SLOT_ADC] ##1 long_call |-> q.idx != `TLVI_SLOT_ADC)
    else $error("serviced a slot absent from the sample");

  AST_CALL_QUALIFIED: assert property (@(posedge clk) disable iff (!rst_n)
    long_call |-> $past(last_cycle) && !$past(wr_irq_reg) && !$past(return_from_interrupt))
    else $error("call raised without a clean final cycle");

  AST_CALL_GATED: assert property (@(posedge clk) disable iff (!rst_n)
    long_call |-> $past(enable_reg_primary[`TLVI_BIT_GATE]))
    else $error("call raised while the global gate was clear");

  AST_CALL_ENABLED: assert property (@(posedge clk) disable iff (!rst_n)
    long_call |-> ($past(en) & (13'h1 << q.idx)) != 13'h0)
    else $error("call raised for a disabled source");

  AST_CALL_SAMPLED: assert property (@(posedge clk) disable iff (!rst_n)
    long_call |-> ($past(q.sample) & (13'h1 << q.idx)) != 13'h0)
    else $error("call raised for a source missing from the last sample");

  AST_LO_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && !service_hi |-> ($past(req) & ((13'h1 << q.idx) - 13'h1)) == 13'h0)
    else $error("low winner skipped an earlier polled request");

  AST_HI_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && service_hi |-> ($past(req & prio_hi) & ((13'h1 << q.idx) - 13'h1)) == 13'h0)
    else $error("high winner skipped an earlier polled request");

  AST_LO_NO_HI_WAITING: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && !service_hi |-> $past(req & prio_hi) == 13'h0)
    else $error("low request served while a high request waited");

  AST_LEVEL_BY_PRIO: assert property (@(posedge clk) disable iff (!rst_n)
    long_call |-> service_hi == (($past(prio_hi) & (13'h1 << q.idx)) != 13'h0))
    else $error("service level does not match the priority bit");

  AST_IDLE_GRANT: assert property (@(posedge clk) disable iff (!rst_n)
    mcyc_start && found && last_cycle && !wr_irq_reg && !return_from_interrupt
      && !service_hi && !service_lo |=> long_call)
    else $error("free poll with a request raised no call");

  AST_NO_REQ_NO_CALL: assert property (@(posedge clk) disable iff (!rst_n)
    mcyc_start && !found |=> !long_call)
    else $error("call raised without any request");

  AST_CLEAR_NEEDS_CALL: assert property (@(posedge clk) disable iff (!rst_n)
    hw_clear != 13'h0 |-> long_call && (hw_clear & ~(13'h1 << q.idx)) == 13'h0)
    else $error("flag clear outside the winning slot");

  AST_EXT0_CLEAR_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && q.idx == `TLVI_SLOT_EXT0 |-> hw_clear[`TLVI_SLOT_EXT0] == $past(ext0_edge))
    else $error("external input a clear does not follow its trigger type");

  AST_LO_RETURN: assert property (@(posedge clk) disable iff (!rst_n)
    mcyc_start && last_cycle && return_from_interrupt && !service_hi && service_lo |=> !service_lo)
    else $error("return did not end low level");

  AST_LO_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    service_lo && !(mcyc_start && last_cycle && return_from_interrupt) |=> service_lo)
    else $error("low level ended without a return");

  AST_HI_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    service_hi && !(mcyc_start && last_cycle && return_from_interrupt) |=> service_hi)
    else $error("high level ended without a return");

  AST_VEC_UARTB: assert property (@(posedge clk) disable iff (!rst_n)
    long_call && q.idx == `TLVI_SLOT_UARTB |-> vector_addr == VEC_UARTB)
    else $error("wrong vector for uart b");

endmodule
`default_nettype wire

// ==== tlvi_core_model.sv ====
`default_nettype none
module tlvi_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pace select
  input  wire logic slow,
  // Machine cycle start
  output var  logic mcyc_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  // The pulse moves on the falling edge so it is settled at the sampling edge.
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 3'h0;
      mcyc_start <= 1'b0;
    end else begin
      cnt        <= cnt + 3'h1;
      mcyc_start <= slow ? (cnt == 3'h7) : (cnt[1:0] == 2'h3);
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] UB = 16'h1234;
  logic        clk = 0, rst_n = 0, mc_s, lc = 0, wr = 0, rt = 0, slow = 0, lvl = 0;
  logic        pin_a = 1, pin_b = 1, call, shi, slo, x0, x1;
  logic [7:0]  ep = 0, ea = 0, pp = 0, ppa = 0, tcr = 8'h05, t2 = 0, ua = 0, ub = 0;
  logic [7:0]  sp = 0, ic = 0, ad = 0, ca = 0;
  logic [31:0] usb = 0;
  logic [15:0] vec;
  logic [12:0] clr;
  int          errors = 0, total_checks = 0;
  logic [15:0] vt [13] = '{16'h0063, 16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
                           16'h0053, 16'h0033, 16'h0043, 16'h003B, 16'h005B, UB};

  always #2.5 clk = ~clk;

  tlvi_core_model tlvi_core_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow), .mcyc_start(mc_s));

  tlvi_ctrl #(.VEC_UARTB(UB)) tlvi_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .mcyc_start(mc_s), .last_cycle(lc), .wr_irq_reg(wr),
    .return_from_interrupt(rt), .enable_reg_primary(ep), .enable_reg_additional(ea),
    .priority_reg_primary(pp), .priority_reg_additional(ppa), .external_irq_a(pin_a),
    .external_irq_b(pin_b), .timer_control_reg(tcr), .timer2_control_reg(t2),
    .uart_a_control_reg(ua), .uart_b_control_reg(ub), .spi_status_reg(sp), .i2c_status_reg(ic),
    .adc_control_reg(ad), .counter_array_status_reg(ca), .usb_flag_regs(usb), .long_call(call),
    .vector_addr(vec), .service_hi(shi), .service_lo(slo), .ext0_pending(x0),
    .ext1_pending(x1), .hw_clear(clr));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One machine cycle: instruction levels are set, then the answer is read in its only cycle.
  task automatic mc(input logic l, w, r, c, input int s);
    logic [12:0] ec;
    ec = (s inside {1, 2, 3, 4, 7, 9} && !(lvl && s inside {1, 3})) ? 13'h1 << s : 13'h0;
    @(negedge clk);
    lc = l;
    wr = w;
    rt = r;
    do @(posedge clk); while (mc_s !== 1'b1);
    @(negedge clk);
    chk("long_call", 16'(call), 16'(c));
    chk("hw_clear", 16'(clr), c ? 16'(ec) : 16'h0000);
    if (c) begin
      chk("vector_addr", vec, vt[s]);
    end
  endtask

  // Peripheral side: raise or drop the flag of one slot.
  task automatic src(input int s, input logic v);
    case (s)
      1: pin_a = !v;
      2: tcr[5] = v;
      3: pin_b = !v;
      4: tcr[7] = v;
      5: ua[0] = v;
      6: t2[6] = v;
      7: sp[3] = v;
      8: usb[31] = v;
      9: ic[5] = v;
      10: ad[7] = v;
      11: ca[7] = v;
      default: ub[1] = v;
    endcase
  endtask

  initial begin
    // The tests need a few microseconds, so this span only runs out on a hang.
    #20us;
    errors++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    chk("long_call", 16'(call), 16'h0000);
    ep = 8'hBF;
    ea = 8'hF3;
    for (int s = 1; s < 13; s++) src(s, 1);
    repeat (3) mc(0, 0, 0, 0, 0);
    for (int s = 1; s < 13; s++) begin
      mc(1, 0, 0, 1, s);
      chk("service_lo", 16'(slo), 16'h0001);
      src(s, 0);
      mc(1, 0, 1, 0, 0);
      chk("service_lo", 16'(slo), 16'h0000);
    end
    chk("ext0_pending", 16'(x0), 16'h0000);
    chk("ext1_pending", 16'(x1), 16'h0000);
    $display("test order done");
    src(5, 1);
    ep = 8'h3F;
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 0, 0);
    ep = 8'h80;
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 0, 0);
    ep = 8'h90;
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 5);
    mc(1, 0, 0, 0, 0);
    chk("service_lo", 16'(slo), 16'h0001);
    mc(1, 0, 1, 0, 0);
    mc(1, 0, 0, 1, 5);
    src(5, 0);
    mc(1, 0, 1, 0, 0);
    $display("test gate done");
    ep = 8'h82;
    ea = 8'h80;
    src(10, 1);
    mc(0, 0, 0, 0, 0);
    mc(1, 1, 0, 0, 0);
    mc(1, 0, 1, 0, 0);
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 10);
    src(10, 0);
    mc(1, 0, 1, 0, 0);
    src(2, 1);
    mc(0, 0, 0, 0, 0);
    src(2, 0);
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 0, 0);
    $display("test block done");
    slow = 1;
    ep = 8'h98;
    pp = 8'h08;
    src(5, 1);
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 5);
    src(5, 0);
    src(10, 1);
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 0, 0);
    src(4, 1);
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 4);
    chk("service_hi", 16'(shi), 16'h0001);
    src(4, 0);
    mc(0, 0, 0, 0, 0);
    src(4, 1);
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 0, 0);
    src(4, 0);
    mc(1, 0, 1, 0, 0);
    chk("service_hi", 16'(shi), 16'h0000);
    chk("service_lo", 16'(slo), 16'h0001);
    mc(1, 0, 0, 0, 0);
    mc(1, 0, 1, 0, 0);
    mc(1, 0, 0, 1, 10);
    src(10, 0);
    mc(1, 0, 1, 0, 0);
    $display("test preempt done");
    slow = 0;
    tcr = 8'h00;
    lvl = 1;
    ep = 8'h81;
    src(1, 1);
    repeat (2) mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 1);
    chk("ext0_pending", 16'(x0), 16'h0001);
    src(1, 0);
    repeat (2) mc(0, 0, 0, 0, 0);
    mc(1, 0, 1, 0, 0);
    chk("ext0_pending", 16'(x0), 16'h0000);
    ep = 8'h84;
    src(3, 1);
    repeat (2) mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 3);
    chk("ext1_pending", 16'(x1), 16'h0001);
    mc(1, 0, 1, 0, 0);
    mc(1, 0, 0, 1, 3);
    src(3, 0);
    repeat (2) mc(0, 0, 0, 0, 0);
    mc(1, 0, 1, 0, 0);
    chk("ext1_pending", 16'(x1), 16'h0000);
    $display("test level done");
    ep = 8'h90;
    src(5, 1);
    mc(0, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 5);
    rst_n = 0;
    repeat (4) @(negedge clk);
    rst_n = 1;
    chk("service_lo", 16'(slo), 16'h0000);
    chk("vector_addr", vec, 16'h0000);
    mc(1, 0, 0, 0, 0);
    mc(1, 0, 0, 1, 5);
    src(5, 0);
    mc(1, 0, 1, 0, 0);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
